// file: hw/pin_select_pkg.sv
// constants and types for the remappable input select block
package pin_select_pkg;
  // ****************************************************************
  // selector layout
  // ****************************************************************
  localparam int          SEL_W         = 5;
  localparam int          PIN_COUNT     = 26;
  localparam int          NUM_SEL       = 12;
  localparam int          HI_LSB        = 8;
  localparam int          LO_LSB        = 0;
  localparam logic [4:0]  SEL_RESET     = 5'h1F;
  localparam logic [4:0]  SEL_LAST_PIN  = 5'h19;
  localparam logic [4:0]  SEL_GROUND    = 5'h1F;
  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0]  ADDR_IRQ1     = 8'h00;
  localparam logic [7:0]  ADDR_IRQ2     = 8'h04;
  localparam logic [7:0]  ADDR_TMR32    = 8'h08;
  localparam logic [7:0]  ADDR_TMR54    = 8'h0C;
  localparam logic [7:0]  ADDR_CAP21    = 8'h10;
  localparam logic [7:0]  ADDR_CAP87    = 8'h14;
  localparam logic [7:0]  ADDR_FAULT    = 8'h18;
  localparam logic [7:0]  ADDR_OSC      = 8'h1C;
  localparam logic [7:0]  ADDR_STATUS   = 8'h20;
  localparam logic [7:0]  ADDR_MASK     = 8'h24;
  localparam logic [7:0]  ADDR_MISMATCH = 8'h28;
  // ****************************************************************
  // oscillator control low byte, unlock sequence and bus response codes
  // ****************************************************************
  localparam int          LOCK_BIT      = 6;
  localparam logic [7:0]  UNLOCK_KEY1   = 8'h46;
  localparam logic [7:0]  UNLOCK_KEY2   = 8'h57;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // status bits
  localparam int          ST_LOCKED_WR  = 0;
  localparam int          ST_LOCK_CHG   = 1;
  localparam int          ST_MISMATCH   = 2;
  localparam int          ST_W          = 3;

  typedef enum logic [1:0] {key_idle, key_one, key_two} unlock_t;

  typedef struct packed {
    logic ext_irq_one;
    logic ext_irq_two;
    logic tmr2_clk;
    logic tmr3_clk;
    logic tmr4_clk;
    logic tmr5_clk;
    logic capture1;
    logic capture2;
    logic capture7;
    logic capture8;
    logic compare_fault_a_input;
  } periph_in_t;
endpackage

// file: hw/remappable_input_select.sv
// remappable input select with lock, shadow monitor and axi4-lite port
`timescale 1ns/100ps
`default_nettype none
module remappable_input_select #(
  parameter int PINS = pin_select_pkg::PIN_COUNT
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // configuration strap
  input  wire logic                     single_session_lock_cfg,
  // remappable pins
  input  wire logic [PINS-1:0]          remap_pin_n,
  // peripheral inputs, mismatch reset and interrupt
  output pin_select_pkg::periph_in_t    periph_in,
  output logic                          config_mismatch_reset,
  output logic                          irq,
  // axi4-lite write address
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);
  localparam int W = pin_select_pkg::SEL_W;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [PINS-1:0] pin_s1;
  logic [PINS-1:0] pin_s2;
  logic [PINS-1:0] pin_s3;
  logic [PINS-1:0] pin_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_q  <= '0;
    end else begin
      pin_s1 <= remap_pin_n;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      // a change counts only once two stages agree
      pin_q  <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));
    end
  end

  // ****************************************************************
  // selector storage
  // ****************************************************************
  // index: 0 irq1, 1 irq2, 2 tmr2, 3 tmr3, 4 tmr4, 5 tmr5,
  // 6 cap1, 7 cap2, 8 cap7, 9 cap8, 10 fault a, 11 spare
  logic [W-1:0] sel    [pin_select_pkg::NUM_SEL];
  logic [W-1:0] shadow [pin_select_pkg::NUM_SEL];
  logic         pin_map_lock;
  logic         lock_once;
  logic         strap_one_way;
  pin_select_pkg::unlock_t key_state;

  function automatic logic route(input logic [W-1:0] s,
                                 input logic [PINS-1:0] p);
    logic r;
    r = 1'b0;
    // values past the last pin, ground code included, stay low
    if (s <= pin_select_pkg::SEL_LAST_PIN && int'(s) < PINS) begin
      r = p[s];
    end
    return r;
  endfunction

  function automatic logic [15:0] pair(input logic [W-1:0] hi,
                                       input logic [W-1:0] lo);
    logic [15:0] v;
    v = '0;
    v[pin_select_pkg::HI_LSB +: W] = hi;
    v[pin_select_pkg::LO_LSB +: W] = lo;
    return v;
  endfunction

  // ****************************************************************
  // axi4-lite slave handshake
  // ****************************************************************
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        rd_fire;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  function automatic logic known(input logic [7:0] a);
    return a <= pin_select_pkg::ADDR_MISMATCH && a[1:0] == 2'h0;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pin_select_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      // locked selector writes still answer okay
      s_axi_bresp  <= known(aw_addr) ? pin_select_pkg::RESP_OKAY
                                     : pin_select_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  logic       sel_wr;
  logic [7:0] lo_byte;
  logic [4:0] hi_f;
  logic [4:0] lo_f;
  logic       osc_wr;

  assign sel_wr  = wr_fire && !pin_map_lock;
  assign lo_byte = w_data[7:0];
  assign hi_f    = w_data[pin_select_pkg::HI_LSB +: W];
  assign lo_f    = w_data[pin_select_pkg::LO_LSB +: W];
  assign osc_wr  = wr_fire && aw_addr == pin_select_pkg::ADDR_OSC
                   && w_strb[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < pin_select_pkg::NUM_SEL; i++) begin
        sel[i] <= pin_select_pkg::SEL_RESET;
      end
    end else if (sel_wr) begin
      if (aw_addr == pin_select_pkg::ADDR_IRQ1) begin
        if (w_strb[1]) sel[0] <= hi_f;
      end else if (aw_addr == pin_select_pkg::ADDR_IRQ2) begin
        if (w_strb[0]) sel[1] <= lo_f;
      end else if (aw_addr == pin_select_pkg::ADDR_TMR32) begin
        if (w_strb[1]) sel[3] <= hi_f;
        if (w_strb[0]) sel[2] <= lo_f;
      end else if (aw_addr == pin_select_pkg::ADDR_TMR54) begin
        if (w_strb[1]) sel[5] <= hi_f;
        if (w_strb[0]) sel[4] <= lo_f;
      end else if (aw_addr == pin_select_pkg::ADDR_CAP21) begin
        if (w_strb[1]) sel[7] <= hi_f;
        if (w_strb[0]) sel[6] <= lo_f;
      end else if (aw_addr == pin_select_pkg::ADDR_CAP87) begin
        if (w_strb[1]) sel[9] <= hi_f;
        if (w_strb[0]) sel[8] <= lo_f;
      end else if (aw_addr == pin_select_pkg::ADDR_FAULT) begin
        if (w_strb[0]) sel[10] <= lo_f;
      end
    end
  end

  // ****************************************************************
  // lock sequencer and one-way strap
  // ****************************************************************
  logic lock_write;
  assign lock_write = osc_wr && key_state == pin_select_pkg::key_two;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_state <= pin_select_pkg::key_idle;
    end else if (osc_wr) begin
      // any other low-byte write restarts the sequence
      if (lo_byte == pin_select_pkg::UNLOCK_KEY1) begin
        key_state <= pin_select_pkg::key_one;
      end else if (key_state == pin_select_pkg::key_one
                   && lo_byte == pin_select_pkg::UNLOCK_KEY2) begin
        key_state <= pin_select_pkg::key_two;
      end else begin
        key_state <= pin_select_pkg::key_idle;
      end
    end
  end

  // strap caught by a clock edge after release, never by the reset
  logic strap_taken;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_taken   <= 1'b0;
      strap_one_way <= 1'b1;
    end else if (!strap_taken) begin
      strap_taken   <= 1'b1;
      strap_one_way <= single_session_lock_cfg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_map_lock <= 1'b0;
      lock_once    <= 1'b0;
    end else if (lock_write) begin
      if (lo_byte[pin_select_pkg::LOCK_BIT]) begin
        pin_map_lock <= 1'b1;
        lock_once    <= 1'b1;
      end else if (!(strap_one_way && lock_once)) begin
        pin_map_lock <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // shadow monitor
  // ****************************************************************
  logic mismatch;
  always_comb begin
    mismatch = 1'b0;
    for (int i = 0; i < pin_select_pkg::NUM_SEL; i++) begin
      if (sel[i] != shadow[i]) mismatch = 1'b1;
    end
  end

  // shadows follow only legal writes, one cycle behind
  logic sel_wr_d;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_wr_d <= 1'b0;
      for (int i = 0; i < pin_select_pkg::NUM_SEL; i++) begin
        shadow[i] <= pin_select_pkg::SEL_RESET;
      end
    end else begin
      sel_wr_d <= sel_wr;
      if (sel_wr_d) begin
        for (int i = 0; i < pin_select_pkg::NUM_SEL; i++) begin
          shadow[i] <= sel[i];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_mismatch_reset <= 1'b0;
    end else begin
      config_mismatch_reset <= mismatch && !sel_wr_d;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  logic [pin_select_pkg::ST_W-1:0] status;
  logic [pin_select_pkg::ST_W-1:0] irq_mask;
  logic [pin_select_pkg::ST_W-1:0] events;
  logic                            status_rd;

  assign events[pin_select_pkg::ST_LOCKED_WR] =
    wr_fire && pin_map_lock && aw_addr < pin_select_pkg::ADDR_OSC;
  assign events[pin_select_pkg::ST_LOCK_CHG] = lock_write;
  assign events[pin_select_pkg::ST_MISMATCH] = config_mismatch_reset;
  assign status_rd = rd_fire && s_axi_araddr == pin_select_pkg::ADDR_STATUS;
  assign irq       = |(status & irq_mask);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      // a new event wins over the clear by read
      status <= (status_rd ? '0 : status) | events;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask <= '0;
    end else if (wr_fire && aw_addr == pin_select_pkg::ADDR_MASK
                 && w_strb[0]) begin
      irq_mask <= w_data[pin_select_pkg::ST_W-1:0];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (s_axi_araddr == pin_select_pkg::ADDR_IRQ1) begin
      rd_word[15:0] = pair(sel[0], '0);
    end else if (s_axi_araddr == pin_select_pkg::ADDR_IRQ2) begin
      rd_word[15:0] = pair('0, sel[1]);
    end else if (s_axi_araddr == pin_select_pkg::ADDR_TMR32) begin
      rd_word[15:0] = pair(sel[3], sel[2]);
    end else if (s_axi_araddr == pin_select_pkg::ADDR_TMR54) begin
      rd_word[15:0] = pair(sel[5], sel[4]);
    end else if (s_axi_araddr == pin_select_pkg::ADDR_CAP21) begin
      rd_word[15:0] = pair(sel[7], sel[6]);
    end else if (s_axi_araddr == pin_select_pkg::ADDR_CAP87) begin
      rd_word[15:0] = pair(sel[9], sel[8]);
    end else if (s_axi_araddr == pin_select_pkg::ADDR_FAULT) begin
      rd_word[15:0] = pair('0, sel[10]);
    end else if (s_axi_araddr == pin_select_pkg::ADDR_OSC) begin
      rd_word[pin_select_pkg::LOCK_BIT] = pin_map_lock;
    end else if (s_axi_araddr == pin_select_pkg::ADDR_STATUS) begin
      rd_word[pin_select_pkg::ST_W-1:0] = status;
    end else if (s_axi_araddr == pin_select_pkg::ADDR_MASK) begin
      rd_word[pin_select_pkg::ST_W-1:0] = irq_mask;
    end else if (s_axi_araddr == pin_select_pkg::ADDR_MISMATCH) begin
      rd_word[0] = mismatch;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= pin_select_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= known(s_axi_araddr) ? pin_select_pkg::RESP_OKAY
                                          : pin_select_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // peripheral routing
  // ****************************************************************
  // only the eleven input selectors of this group exist here; the rest
  // of the twenty-seven live in sibling blocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_in <= '0;
    end else begin
      periph_in.ext_irq_one           <= route(sel[0], pin_q);
      periph_in.ext_irq_two           <= route(sel[1], pin_q);
      periph_in.tmr2_clk              <= route(sel[2], pin_q);
      periph_in.tmr3_clk              <= route(sel[3], pin_q);
      periph_in.tmr4_clk              <= route(sel[4], pin_q);
      periph_in.tmr5_clk              <= route(sel[5], pin_q);
      periph_in.capture1              <= route(sel[6], pin_q);
      periph_in.capture2              <= route(sel[7], pin_q);
      periph_in.capture7              <= route(sel[8], pin_q);
      periph_in.capture8              <= route(sel[9], pin_q);
      periph_in.compare_fault_a_input <= route(sel[10], pin_q);
    end
  end
endmodule
`default_nettype wire

// file: tb/pin_select_monitor.sv
// concurrent checks on the remappable input select ports
`timescale 1ns/100ps
`default_nettype none
module pin_select_monitor (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // peripheral side
  input wire pin_select_pkg::periph_in_t periph_in,
  input wire logic                       config_mismatch_reset,
  // register bus
  input wire logic [7:0]                 s_axi_awaddr,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [7:0]                 s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready
);
  // ********
  // steps
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ********
  // checks
  // ********
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  aw_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  // both items are held for one cycle before the answer is registered
  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  bad_wr_a: assert property (wr_taken ##0 (s_axi_awaddr > 8'h28) |-> ##2
    s_axi_bresp == pin_select_pkg::RESP_SLVERR) else $error("bad write ok");
  bad_rd_a: assert property (rd_taken ##0 (s_axi_araddr > 8'h28) |=>
    s_axi_rresp == pin_select_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("bad read ok");
  sel_zero_a: assert property (rd_taken ##0 (s_axi_araddr < 8'h1C) |=>
    (s_axi_rdata & 32'hFFFFE0E0) == 32'h0) else $error("unused bits set");
  quiet_a: assert property (!config_mismatch_reset)
    else $error("mismatch reset raised");
  reset_low_a: assert property ($fell(rst) |->
    (periph_in == 11'h000) [*3]) else $error("input not tied low");
endmodule
`default_nettype wire

// file: tb/pin_bank_model.sv
// behavioural model of the remappable pin bank
`timescale 1ns/100ps
`default_nettype none
module pin_bank_model (
  // clock
  input  wire logic        clk,
  // requested levels
  input  wire logic [25:0] level,
  // pins toward the block
  output var  logic [25:0] pins
);
  // pins are asynchronous to the block; move them off its sampling edge
  always @(negedge clk) pins <= level;
endmodule
`default_nettype wire

// file: tb/tb_remappable_input_select.sv
// self-checking bench for the remappable input select block
`timescale 1ns/100ps
`default_nettype none
module tb_remappable_input_select;
  // ********
  // signals
  // ********
  logic        clk, rst, single_session_lock_cfg, irq, config_mismatch_reset;
  logic [25:0] level, remap_pin_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [10:0] e;
  int          n_errors, tests_run, cyc;
  pin_select_pkg::periph_in_t periph_in;
  logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rm [7] = '{32'h1F00, 32'h1F, 32'h1F1F, 32'h1F1F, 32'h1F1F,
                          32'h1F1F, 32'h1F};
  logic [31:0] fv [7] = '{32'h0100, 32'h02, 32'h0304, 32'h0506, 32'h0708,
                          32'h090A, 32'h0B};
  // pin chosen for each peripheral input, msb of the struct first
  int          ps [11] = '{1, 2, 4, 3, 6, 5, 8, 7, 10, 9, 11};
  pin_bank_model i_pins (.clk(clk), .level(level), .pins(remap_pin_n));
  remappable_input_select i_dut (
    .clk(clk), .rst(rst), .single_session_lock_cfg(single_session_lock_cfg),
    .remap_pin_n(remap_pin_n), .periph_in(periph_in),
    .config_mismatch_reset(config_mismatch_reset), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ********
  // tasks
  // ********
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the master never assumes a latency: it waits on the answer itself
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w, b;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] ex);
    logic ar, r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(rd & m, ex);
  endtask
  task automatic lockseq(input logic [7:0] v);
    wr(8'h1C, 32'h46, 2'h0);
    wr(8'h1C, 32'h57, 2'h0);
    wr(8'h1C, {24'h0, v}, 2'h0);
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  // ********
  // tests
  // ********
  initial begin
    rst = 1'b1;
    single_session_lock_cfg = 1'b0;
    level = 26'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {n_errors, tests_run, cyc} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rdc(ra[i], 32'hFFFFFFFF, rm[i]);
      wr(ra[i], 32'hFFFFFFFF, 2'h0);
      rdc(ra[i], 32'hFFFFFFFF, rm[i]);
      wr(ra[i], fv[i], 2'h0);
    end
    $display("test layout done");
    for (int k = 0; k < 26; k++) begin
      @(posedge clk);
      level <= 26'h1 << k;
      settle;
      for (int j = 0; j < 11; j++) e[10-j] = (k == ps[j]);
      chk({21'h0, periph_in}, {21'h0, e});
    end
    $display("test field routing done");
    for (int n = 0; n < 32; n++) begin
      wr(8'h04, n, 2'h0);
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        level <= p ? 26'h1555555 : 26'h2AAAAAA;
        settle;
        e[0] = (n < 26) ? (p ? n % 2 == 0 : n % 2 == 1) : 1'b0;
        chk({31'h0, periph_in.ext_irq_two}, {31'h0, e[0]});
      end
    end
    $display("test value sweep done");
    wr(8'h24, 32'h1, 2'h0);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    lockseq(8'h40);
    rdc(8'h1C, 32'h40, 32'h40);
    wr(8'h04, 32'h0, 2'h0);
    rdc(8'h04, 32'hFFFFFFFF, 32'h1F);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    rdc(8'h20, 32'hFFFFFFFF, 32'h3);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    // a broken key sequence must leave the lock where it was
    wr(8'h1C, 32'h46, 2'h0);
    wr(8'h1C, 32'h12, 2'h0);
    wr(8'h1C, 32'h00, 2'h0);
    rdc(8'h1C, 32'h40, 32'h40);
    lockseq(8'h00);
    rdc(8'h1C, 32'h40, 32'h0);
    wr(8'h04, 32'h5, 2'h0);
    rdc(8'h04, 32'hFFFFFFFF, 32'h5);
    rdc(8'h28, 32'hFFFFFFFF, 32'h0);
    rdc(8'h2C, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, rs}, {30'h0, pin_select_pkg::RESP_SLVERR});
    wr(8'h30, 32'h1, pin_select_pkg::RESP_SLVERR);
    $display("test lock and interrupt done");
    @(posedge clk);
    rst <= 1'b1;
    single_session_lock_cfg <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    lockseq(8'h40);
    lockseq(8'h00);
    rdc(8'h1C, 32'h40, 32'h40);
    wr(8'h00, 32'h0, 2'h0);
    rdc(8'h00, 32'hFFFFFFFF, 32'h1F00);
    $display("test single session done");
    stop_test;
  end
endmodule
bind remappable_input_select pin_select_monitor i_mon (
  .clk(clk), .rst(rst), .periph_in(periph_in),
  .config_mismatch_reset(config_mismatch_reset),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire
